// ===== trbg_collect.sv
// shift collector that gathers processed bits into whole bytes
// assumes bitValid is a one-cycle strobe, cleared with run low
`timescale 1ns/10ps
module trbg_collect import trbg_pkg::*; #(
  parameter int WIDTH = BYTE_W
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  input wire logic bitValid,
  input wire logic bitValue,
  output logic byteValid,
  output logic [WIDTH-1:0] byteOut
);
  localparam int CNT_W = $clog2(WIDTH);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(WIDTH - 1);
  logic [WIDTH-1:0] shift_q;
  logic [CNT_W-1:0] count_q;
  if (WIDTH < 2) begin : g_check
    $error("collector needs at least two bits");
  end
  // ==========================================================
  // partial bytes are thrown away when generation halts
  always_ff @(posedge clock) begin
    if (reset || !run) begin
      shift_q <= '0;
      count_q <= '0;
      byteValid <= 1'b0;
      byteOut <= '0;
    end else begin
      byteValid <= 1'b0;
      if (bitValid) begin
        shift_q <= {shift_q[WIDTH-2:0], bitValue};
        if (count_q == LAST) begin
          count_q <= '0;
          byteValid <= 1'b1;
          byteOut <= {shift_q[WIDTH-2:0], bitValue};
        end else begin
          count_q <= count_q + 1'b1;
        end
      end
    end
  end
  a_byte_at_last: assert property (@(posedge clock) disable iff (reset)
    run && bitValid && (count_q == LAST) |=> byteValid || !run)
    else $error("byte not completed at last bit");
endmodule // trbg_collect

// ===== trbg_debias.sv
// pairwise bias remover for the raw noise stream
// assumes sampleValid marks each fresh raw noise bit, synchronous to clock
`timescale 1ns/10ps
module trbg_debias import trbg_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  input wire logic run,
  input wire logic enable,
  input wire logic sampleValid,
  input wire logic rawBit,
  output logic bitValid,
  output logic bitValue
);
  logic first_q;
  logic haveFirst_q;
  // ==========================================================
  // pair filter: 10 gives 1, 01 gives 0, equal pairs dropped
  always_ff @(posedge clock) begin
    if (reset || !run) begin
      first_q <= 1'b0;
      haveFirst_q <= 1'b0;
      bitValid <= 1'b0;
      bitValue <= 1'b0;
    end else begin
      bitValid <= 1'b0;
      if (sampleValid) begin
        if (!enable) begin
          bitValid <= 1'b1;
          bitValue <= rawBit;
        end else if (!haveFirst_q) begin
          first_q <= rawBit;
          haveFirst_q <= 1'b1;
        end else begin
          haveFirst_q <= 1'b0;
          if (first_q != rawBit) begin
            bitValid <= 1'b1;
            bitValue <= first_q;
          end
        end
      end
    end
  end
  a_pair_equal_drop: assert property (@(posedge clock) disable iff (reset)
    run && enable && sampleValid && haveFirst_q && (first_q == rawBit) ##1 run |-> !bitValid)
    else $error("equal pair produced a bit");
endmodule // trbg_debias

// ===== trbg_pkg.sv
// constants, bus carriers and the decode helper of the random byte generator
// assumes a 32-bit classic wishbone fabric with byte addressing
package trbg_pkg;
  // ==========================================================
  // register byte offsets
  localparam int ADR_W = 12;
  localparam logic [ADR_W-1:0] OFS_START = 12'h000;
  localparam logic [ADR_W-1:0] OFS_STOP = 12'h004;
  localparam logic [ADR_W-1:0] OFS_EVENT = 12'h100;
  localparam logic [ADR_W-1:0] OFS_SHORT = 12'h200;
  localparam logic [ADR_W-1:0] OFS_IRQSET = 12'h304;
  localparam logic [ADR_W-1:0] OFS_IRQCLR = 12'h308;
  localparam logic [ADR_W-1:0] OFS_CONFIG = 12'h504;
  localparam logic [ADR_W-1:0] OFS_READOUT = 12'h508;
  // ==========================================================
  // field positions and reset values
  localparam int FLD_TRIGGER = 0;
  localparam int FLD_EVENT = 0;
  localparam int FLD_SHORT = 0;
  localparam int FLD_IRQEN = 0;
  localparam int FLD_DEBIAS = 0;
  localparam int BYTE_W = 8;
  localparam logic RST_EVENT = 1'b0;
  localparam logic RST_SHORT = 1'b0;
  localparam logic RST_IRQEN = 1'b0;
  localparam logic RST_DEBIAS = 1'b0;
  localparam logic [BYTE_W-1:0] RST_READOUT = 8'h00;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } trbg_state_t;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } trbg_wbreq_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } trbg_wbrsp_t;
  // ==========================================================
  // word decode, low two address bits ignored
  function automatic logic trbgHit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] ofs);
    trbgHit = (adr[ADR_W-1:2] == ofs[ADR_W-1:2]);
  endfunction
endpackage

// ===== trbg_tb.sv
// self-checking bench of the random byte generator
// assumes trbg_pkg and trbg_top compiled first; bench drives bus and noise itself
`timescale 1ns/10ps
module tb import trbg_pkg::*;;
  // ==========================================================
  // stimulus signals
  logic clock;
  logic reset;
  trbg_wbreq_t wbReq;
  trbg_wbrsp_t wbRsp;
  logic noiseValid;
  logic noiseBit;
  logic irq;
  logic [31:0] rs;
  logic [31:0] expQ[$];
  string nameQ[$];
  int errTotal;
  int samplesChecked;
  logic [7:0] v;
  logic [7:0] last;

  trbg_top uut (
    .clock(clock),
    .reset(reset),
    .wbReq(wbReq),
    .wbRsp(wbRsp),
    .noiseValid(noiseValid),
    .noiseBit(noiseBit),
    .irq(irq)
  );

  always #4 clock = ~clock;

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic endSim();
    $display("checked %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // one classic cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 20);
    wbReq <= '0;
    if (n >= 20) begin
      errTotal++;
      endSim();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    expQ.push_back(e);
    nameQ.push_back(nm);
    wb(1'b0, a, 32'h0);
  endtask

  // one raw sample, then an idle cycle carrying junk
  task automatic sendBit(input logic b);
    @(posedge clock);
    noiseValid <= 1'b1;
    noiseBit <= b;
    @(posedge clock);
    noiseValid <= 1'b0;
    noiseBit <= ~b;
  endtask

  // with correction, random equal pairs are slipped in; they must be dropped
  task automatic genByte(input logic deb, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      rs = xs(rs);
      if (deb && rs[0]) begin
        sendBit(rs[1]);
        sendBit(rs[1]);
      end
      sendBit(b[i]);
      if (deb) begin
        sendBit(~b[i]);
      end
    end
  endtask

  task automatic waitIrq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 200) begin
      @(posedge clock);
      n++;
    end
    if (n >= 200) begin
      errTotal++;
      endSim();
    end
  endtask

  // ==========================================================
  // monitor: each read answer takes the oldest note
  always @(posedge clock) begin
    if (wbRsp.ack === 1'b1 && wbReq.cyc === 1'b1 && wbReq.we === 1'b0) begin
      if (expQ.size() == 0) begin
        chk("stray read", 32'h1, 32'h0);
      end else begin
        chk(nameQ.pop_front(), wbRsp.dat, expQ.pop_front());
      end
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    wbReq = '0;
    noiseValid = 1'b0;
    noiseBit = 1'b0;
    rs = 32'd9836;
    errTotal = 0;
    samplesChecked = 0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(OFS_EVENT, 32'h0, "event rst");
    rd(OFS_SHORT, 32'h0, "short rst");
    rd(OFS_IRQSET, 32'h0, "irqen rst");
    rd(OFS_CONFIG, 32'h0, "config rst");
    rd(OFS_READOUT, 32'h0, "readout rst");
    rd(12'h0f0, 32'h0, "unmapped");
    wb(1'b1, OFS_IRQSET, 32'h0);
    rd(OFS_IRQCLR, 32'h0, "w0 no effect");
    wb(1'b1, OFS_IRQSET, 32'h1);
    rd(OFS_IRQCLR, 32'h1, "irqen set");
    wb(1'b1, OFS_START, 32'h1);
    rd(OFS_START, 32'h0, "task read");
    // two plain bytes back to back, then two with correction
    for (int k = 0; k < 4; k++) begin
      if (k == 2) begin
        wb(1'b1, OFS_CONFIG, 32'h1);
        rd(OFS_CONFIG, 32'h1, "config");
      end
      rs = xs(rs);
      v = rs[7:0];
      genByte(k >= 2, v);
      waitIrq();
      rd(OFS_READOUT, {24'h0, v}, "byte");
      rd(OFS_EVENT, 32'h1, "event");
      wb(1'b1, OFS_EVENT, 32'h1);
      repeat (2) @(posedge clock);
      chk("irq clr", {31'h0, irq}, 32'h0);
    end
    last = v;
    // stop mid-byte: partial bits dropped, later samples ignored
    wb(1'b1, OFS_CONFIG, 32'h0);
    for (int i = 0; i < 4; i++) sendBit(rs[i]);
    wb(1'b1, OFS_STOP, 32'h1);
    genByte(1'b0, 8'h5a);
    repeat (4) @(posedge clock);
    rd(OFS_EVENT, 32'h0, "stopped");
    rd(OFS_READOUT, {24'h0, last}, "kept");
    wb(1'b1, OFS_START, 32'h1);
    rs = xs(rs);
    v = rs[7:0];
    genByte(1'b0, v);
    waitIrq();
    rd(OFS_READOUT, {24'h0, v}, "restart");
    wb(1'b1, OFS_EVENT, 32'h1);
    // shortcut: first event halts generation
    wb(1'b1, OFS_SHORT, 32'h1);
    rd(OFS_SHORT, 32'h1, "short");
    rs = xs(rs);
    v = rs[7:0];
    genByte(1'b0, v);
    waitIrq();
    wb(1'b1, OFS_EVENT, 32'h1);
    genByte(1'b0, ~v);
    repeat (4) @(posedge clock);
    rd(OFS_EVENT, 32'h0, "short stop");
    rd(OFS_READOUT, {24'h0, v}, "short val");
    wb(1'b1, OFS_SHORT, 32'h0);
    // masked event keeps irq low until enabled
    wb(1'b1, OFS_IRQCLR, 32'h1);
    rd(OFS_IRQSET, 32'h0, "irqen clr");
    wb(1'b1, OFS_START, 32'h1);
    genByte(1'b0, 8'ha5);
    repeat (8) @(posedge clock);
    chk("irq masked", {31'h0, irq}, 32'h0);
    rd(OFS_EVENT, 32'h1, "event masked");
    rd(OFS_READOUT, 32'h0000_00a5, "masked val");
    wb(1'b1, OFS_IRQSET, 32'h1);
    repeat (3) @(posedge clock);
    chk("irq unmask", {31'h0, irq}, 32'h1);
    wb(1'b1, OFS_STOP, 32'h1);
    endSim();
  end
endmodule // tb

// ===== trbg_top.sv
// random byte generator: task control, byte readout, event and interrupt
// assumes a classic wishbone master and a raw noise bit stream input
//
// Overview of operation
// - start task begins generation, stop task ends it.
// - running generator produces bytes continuously, each loaded into readout.
// - one value-ready event per byte placed in readout.
// - with correction on, raw bits are debiased pairwise before use.
// - processed bits shift into an eight-bit collector, then readout.
// - a config bit turns bias correction on or off.
// - byte interval varies with the noise, more with correction on.
// - no seed is loaded; output depends only on the noise.
// - shortcut bit set makes each value-ready event trigger stop; resets 0.
// - interrupt enable set and clear by writing one; reads show state.
`timescale 1ns/10ps
module trbg_top import trbg_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  input wire trbg_wbreq_t wbReq,
  output trbg_wbrsp_t wbRsp,
  input wire logic noiseValid,
  input wire logic noiseBit,
  output logic irq
);
  // ==========================================================
  // declarations
  trbg_state_t state_q;
  trbg_state_t state_d;
  trbg_wbrsp_t wbRsp_q;
  logic event_q;
  logic shortcut_q;
  logic irqEn_q;
  logic debias_q;
  logic irq_q;
  logic [BYTE_W-1:0] readout_q;
  logic running;
  logic reqLive;
  logic wrStrobe;
  logic wrLane0;
  logic startHit;
  logic stopHit;
  logic shortStop;
  logic procValid;
  logic procBit;
  logic byteValid;
  logic [BYTE_W-1:0] collByte;
  logic [31:0] rdData;

  assign running = (state_q == ST_RUN);

  // ==========================================================
  // bus strobes
  // writes act on the edge where ack is seen high, as the master expects
  assign reqLive = wbReq.cyc && wbReq.stb;
  assign wrStrobe = reqLive && wbReq.we && wbRsp_q.ack;
  assign wrLane0 = wrStrobe && wbReq.sel[0];

  assign startHit = wrLane0 && trbgHit(wbReq.adr, OFS_START) &&
    wbReq.dat[FLD_TRIGGER];
  assign stopHit = wrLane0 && trbgHit(wbReq.adr, OFS_STOP) &&
    wbReq.dat[FLD_TRIGGER];
  assign shortStop = byteValid && shortcut_q;

  // ==========================================================
  // noise path
  // no seed state anywhere: output depends on the noise alone
  trbg_debias u_debias (
    .clock(clock),
    .reset(reset),
    .run(running),
    .enable(debias_q),
    .sampleValid(noiseValid),
    .rawBit(noiseBit),
    .bitValid(procValid),
    .bitValue(procBit)
  );

  // interval per byte follows the noise and the pair drop rate
  trbg_collect #(
    .WIDTH(BYTE_W)
  ) u_collect (
    .clock(clock),
    .reset(reset),
    .run(running),
    .bitValid(procValid),
    .bitValue(procBit),
    .byteValid(byteValid),
    .byteOut(collByte)
  );

  // ==========================================================
  // run control
  // stop beats start when both land in one cycle
  // a shortcut stop from a late byte beats a start too
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (startHit && !stopHit && !shortStop) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (stopHit || shortStop) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // readout
  // no hold-off: an unread byte is simply replaced
  always_ff @(posedge clock) begin
    if (reset) begin
      readout_q <= RST_READOUT;
    end else if (byteValid) begin
      readout_q <= collByte;
    end
  end

  // ==========================================================
  // value-ready event, write one clears, new byte wins
  always_ff @(posedge clock) begin
    if (reset) begin
      event_q <= RST_EVENT;
    end else if (byteValid) begin
      event_q <= 1'b1;
    end else if (wrLane0 && trbgHit(wbReq.adr, OFS_EVENT) && wbReq.dat[FLD_EVENT]) begin
      event_q <= 1'b0;
    end
  end

  // ==========================================================
  // shortcut and config
  always_ff @(posedge clock) begin
    if (reset) begin
      shortcut_q <= RST_SHORT;
    end else if (wrLane0 && trbgHit(wbReq.adr, OFS_SHORT)) begin
      shortcut_q <= wbReq.dat[FLD_SHORT];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      debias_q <= RST_DEBIAS;
    end else if (wrLane0 && trbgHit(wbReq.adr, OFS_CONFIG)) begin
      debias_q <= wbReq.dat[FLD_DEBIAS];
    end
  end

  // ==========================================================
  // interrupt enable and output
  // writing zero to either port leaves the enable alone
  always_ff @(posedge clock) begin
    if (reset) begin
      irqEn_q <= RST_IRQEN;
    end else if (wrLane0 && trbgHit(wbReq.adr, OFS_IRQSET) && wbReq.dat[FLD_IRQEN]) begin
      irqEn_q <= 1'b1;
    end else if (wrLane0 && trbgHit(wbReq.adr, OFS_IRQCLR) && wbReq.dat[FLD_IRQEN]) begin
      irqEn_q <= 1'b0;
    end
  end

  // one cycle behind the event, traded for a flop-driven pin
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= event_q && irqEn_q;
    end
  end

  assign irq = irq_q;

  // ==========================================================
  // read mux, tasks and holes read zero
  always_comb begin
    rdData = 32'h0000_0000;
    if (trbgHit(wbReq.adr, OFS_EVENT)) begin
      rdData[FLD_EVENT] = event_q;
    end else if (trbgHit(wbReq.adr, OFS_SHORT)) begin
      rdData[FLD_SHORT] = shortcut_q;
    end else if (trbgHit(wbReq.adr, OFS_IRQSET) || trbgHit(wbReq.adr, OFS_IRQCLR)) begin
      rdData[FLD_IRQEN] = irqEn_q;
    end else if (trbgHit(wbReq.adr, OFS_CONFIG)) begin
      rdData[FLD_DEBIAS] = debias_q;
    end else if (trbgHit(wbReq.adr, OFS_READOUT)) begin
      rdData[BYTE_W-1:0] = readout_q;
    end
  end

  // ==========================================================
  // bus answer: ack one cycle after the request, dropped next cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      wbRsp_q <= '0;
    end else begin
      wbRsp_q.ack <= reqLive && !wbRsp_q.ack;
      if (reqLive && !wbRsp_q.ack && !wbReq.we) begin
        wbRsp_q.dat <= rdData;
      end
    end
  end

  assign wbRsp = wbRsp_q;

  // ==========================================================
  // checks
  a_start_runs: assert property (@(posedge clock) disable iff (reset)
    (state_q == ST_IDLE) && startHit && !stopHit && !shortStop |=> (state_q == ST_RUN))
    else $error("start task did not start generation");

  a_stop_halts: assert property (@(posedge clock) disable iff (reset)
    stopHit |=> (state_q == ST_IDLE))
    else $error("stop task did not halt generation");

  a_idle_silent: assert property (@(posedge clock) disable iff (reset)
    (state_q == ST_IDLE) [*2] |-> !byteValid && !procValid)
    else $error("production while halted");

  a_byte_loaded: assert property (@(posedge clock) disable iff (reset)
    byteValid |=> (readout_q == $past(collByte)))
    else $error("readout not loaded with new byte");

  a_event_raised: assert property (@(posedge clock) disable iff (reset)
    byteValid |=> event_q ##1 (irq_q == irqEn_q || $past(irqEn_q) != irqEn_q))
    else $error("event missing after new byte");

  a_readout_steady: assert property (@(posedge clock) disable iff (reset)
    !byteValid |=> $stable(readout_q))
    else $error("readout changed without a byte");

  a_shortcut_stop: assert property (@(posedge clock) disable iff (reset)
    byteValid && shortcut_q |=> (state_q == ST_IDLE))
    else $error("shortcut did not stop generation");

  a_irq_follow: assert property (@(posedge clock) disable iff (reset)
    event_q && irqEn_q |=> irq_q)
    else $error("interrupt not raised");

  a_irq_gated: assert property (@(posedge clock) disable iff (reset)
    !irqEn_q |=> !irq_q)
    else $error("interrupt while disabled");

  a_ack_single: assert property (@(posedge clock) disable iff (reset)
    wbRsp_q.ack |=> !wbRsp_q.ack)
    else $error("ack held two cycles");

  a_upper_zero: assert property (@(posedge clock) disable iff (reset)
    wbRsp_q.ack && !wbReq.we && trbgHit(wbReq.adr, OFS_READOUT) |->
    (wbRsp_q.dat[31:BYTE_W] == '0))
    else $error("readout upper bits not zero");

  // ==========================================================
  // run and event checks
  a_idle_holds: assert property (@(posedge clock) disable iff (reset)
    (state_q == ST_IDLE) && !startHit |=> (state_q == ST_IDLE))
    else $error("generation started without a start task");

  a_byte_needs_run: assert property (@(posedge clock) disable iff (reset)
    byteValid |-> ($past(state_q) == ST_RUN))
    else $error("byte completed while halted");

  a_run_holds: assert property (@(posedge clock) disable iff (reset)
    (state_q == ST_RUN) && !stopHit && !shortStop |=> (state_q == ST_RUN))
    else $error("generation halted without a stop");

  a_event_cleared: assert property (@(posedge clock) disable iff (reset)
    event_q && !byteValid && wrLane0 && trbgHit(wbReq.adr, OFS_EVENT) &&
    wbReq.dat[FLD_EVENT] |=> !event_q)
    else $error("event not cleared by write one");

  a_event_sticky: assert property (@(posedge clock) disable iff (reset)
    event_q && !(wrLane0 && trbgHit(wbReq.adr, OFS_EVENT)) |=> event_q)
    else $error("event dropped without a clear");

  a_event_needs_byte: assert property (@(posedge clock) disable iff (reset)
    !event_q && !byteValid |=> !event_q)
    else $error("event raised without a byte");

  a_short_write: assert property (@(posedge clock) disable iff (reset)
    wrLane0 && trbgHit(wbReq.adr, OFS_SHORT) |=>
    (shortcut_q == $past(wbReq.dat[FLD_SHORT])))
    else $error("shortcut bit not written");

  a_short_off_runs: assert property (@(posedge clock) disable iff (reset)
    (state_q == ST_RUN) && byteValid && !shortcut_q && !stopHit |=> (state_q == ST_RUN))
    else $error("byte halted generation with shortcut off");

  // ==========================================================
  // register and bus checks
  a_config_write: assert property (@(posedge clock) disable iff (reset)
    wrLane0 && trbgHit(wbReq.adr, OFS_CONFIG) |=>
    (debias_q == $past(wbReq.dat[FLD_DEBIAS])))
    else $error("correction bit not written");

  a_irqen_set: assert property (@(posedge clock) disable iff (reset)
    wrLane0 && trbgHit(wbReq.adr, OFS_IRQSET) && wbReq.dat[FLD_IRQEN] |=> irqEn_q)
    else $error("interrupt enable not set");

  a_irqen_clear: assert property (@(posedge clock) disable iff (reset)
    wrLane0 && trbgHit(wbReq.adr, OFS_IRQCLR) && wbReq.dat[FLD_IRQEN] |=> !irqEn_q)
    else $error("interrupt enable not cleared");

  a_irqen_zero: assert property (@(posedge clock) disable iff (reset)
    wrLane0 && (trbgHit(wbReq.adr, OFS_IRQSET) || trbgHit(wbReq.adr, OFS_IRQCLR)) &&
    !wbReq.dat[FLD_IRQEN] |=> $stable(irqEn_q))
    else $error("writing zero changed interrupt enable");

  a_irq_source: assert property (@(posedge clock) disable iff (reset)
    irq_q |-> $past(event_q) && $past(irqEn_q))
    else $error("interrupt without enabled event");

  a_ack_answer: assert property (@(posedge clock) disable iff (reset)
    reqLive && !wbRsp_q.ack |=> wbRsp_q.ack)
    else $error("request not acknowledged");

  a_read_capture: assert property (@(posedge clock) disable iff (reset)
    reqLive && !wbRsp_q.ack && !wbReq.we |=> (wbRsp_q.dat == $past(rdData)))
    else $error("read data not captured");

  a_readout_value: assert property (@(posedge clock) disable iff (reset)
    wbRsp_q.ack && reqLive && !wbReq.we && trbgHit(wbReq.adr, OFS_READOUT) |->
    (wbRsp_q.dat[BYTE_W-1:0] == $past(readout_q)))
    else $error("readout read returned wrong byte");

  a_task_reads_zero: assert property (@(posedge clock) disable iff (reset)
    wbRsp_q.ack && reqLive && !wbReq.we &&
    (trbgHit(wbReq.adr, OFS_START) || trbgHit(wbReq.adr, OFS_STOP)) |->
    (wbRsp_q.dat == 32'h0000_0000))
    else $error("task register read not zero");

endmodule // trbg_top
